// *** oag_map.sv ***
// Direct operand mapper: 8-bit or 4-bit operand to 12-bit register address.
// Purely combinational; used for both first-level and pointer-fetch addresses.
`timescale 1ns/1ns
module oag_map
    import oag_pkg::*;
(
    input  wire logic [7:0]  register_pointer,
    input  wire logic [7:0]  operand,
    input  wire logic        working,
    output logic      [11:0] addr
);
    always_comb begin
        if (working) begin
            addr = {register_pointer[3:0], register_pointer[7:4], operand[3:0]};
        end else if (operand >= OAG_ESC_LO && operand <= OAG_ESC_HI) begin
            addr = {register_pointer[3:0], register_pointer[7:4], operand[3:0]};
        end else begin
            addr = {register_pointer[3:0], operand};
        end
    end
endmodule // oag_map

// *** oag_pkg.sv ***
// Operand address generator package: modes, request and answer carriers.
// Assumes a single CPU clock domain and a synchronous decoder front end.
// Functional notes
// - Register operand 00h-DFh or F0h-FFh maps to pointer low nibble plus operand.
// - Register operand E0h-EFh maps to pointer low, pointer high, operand low nibble.
// - Indirect working register: read register, address is pointer low plus value.
// - Indirect working pair gives 12-bit register or 16-bit program address.
// - Indirect register: fetch named register, address is pointer low plus value.
// - Indirect register pair value is a 16-bit program memory address.
// - Indexed: signed working-register offset plus base, then pointer low prefix.
// - Absolute jump or call loads the 16-bit direct address into the counter.
// - Relative jump adds signed 8-bit offset to next instruction address.
// - Four-bit working register maps to pointer low, pointer high, index.
package oag_pkg;

    localparam int OAG_RF_AW = 12;
    localparam int OAG_PM_AW = 16;
    localparam logic [7:0] OAG_ESC_LO = 8'hE0;
    localparam logic [7:0] OAG_ESC_HI = 8'hEF;
    localparam logic [3:0] OAG_WR_FETCH_LAT = 4'h1;

    typedef enum logic [3:0] {
        OAG_M_WORK     = 4'h0,
        OAG_M_REG      = 4'h1,
        OAG_M_IND_WORK = 4'h2,
        OAG_M_IND_WPR  = 4'h3,
        OAG_M_IND_REG  = 4'h4,
        OAG_M_IND_RPR  = 4'h5,
        OAG_M_INDEX    = 4'h6,
        OAG_M_ABS_JMP  = 4'h7,
        OAG_M_REL_JMP  = 4'h8
    } oag_mode_e;

    typedef struct packed {
        oag_mode_e   mode;
        logic [7:0]  operand;
        logic [15:0] direct_program_address;
        logic [7:0]  relative_branch_offset;
        logic [15:0] next_pc;
        logic        pair_to_program;
    } oag_req_s;

    typedef struct packed {
        logic        rf_valid;
        logic [11:0] rf_addr;
        logic        pm_valid;
        logic [15:0] pm_addr;
        logic        pc_load;
        logic [15:0] pc_value;
    } oag_rsp_s;

endpackage

// *** oag_top.sv ***
// Operand address generator top: forms register-file and program addresses.
// Assumes the register file answers a fetch one cycle after RF_FETCH_* is set.
`timescale 1ns/1ns
module oag_top
    import oag_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        REQ_VALID,
    input  wire oag_req_s    REQ,
    input  wire logic [7:0]  REGISTER_POINTER,
    input  wire logic [15:0] RF_RDATA,
    output logic             BUSY,
    output logic             RF_FETCH_VALID,
    output logic      [11:0] RF_FETCH_ADDR,
    output logic             RF_FETCH_PAIR,
    output oag_rsp_s         RSP
);
    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OAG_S_IDLE  = 2'b00,
        OAG_S_FETCH = 2'b01,
        OAG_S_USE   = 2'b10
    } oag_state_e;

    oag_state_e  state_reg;
    oag_req_s    req_reg;
    logic [7:0]  rp_reg;
    logic [11:0] first_addr;
    logic [11:0] fetch_addr;
    logic        need_fetch;
    logic        fetch_pair;
    logic [7:0]  index_sum;

    oag_map oag_map_i (
        .register_pointer (REGISTER_POINTER),
        .operand          (REQ.operand),
        .working          (REQ.mode inside {OAG_M_WORK, OAG_M_IND_WORK, OAG_M_IND_WPR,
                                            OAG_M_INDEX}),
        .addr             (first_addr)
    );

    function automatic logic [15:0] oag_rel(input logic [15:0] pc, input logic [7:0] off);
        oag_rel = pc + {{8{off[7]}}, off};
    endfunction

    always_comb begin
        need_fetch = REQ.mode inside {OAG_M_IND_WORK, OAG_M_IND_WPR, OAG_M_IND_REG,
                                      OAG_M_IND_RPR, OAG_M_INDEX};
        fetch_pair = REQ.mode inside {OAG_M_IND_WPR, OAG_M_IND_RPR};
        // Indexed mode fetches the offset register; the base is the operand itself.
        fetch_addr = (REQ.mode == OAG_M_INDEX)
                   ? {REGISTER_POINTER[3:0], REGISTER_POINTER[7:4],
                      REQ.relative_branch_offset[3:0]}
                   : first_addr;
        index_sum  = req_reg.operand + RF_RDATA[7:0];
    end

    // ------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state_reg      <= OAG_S_IDLE;
            req_reg        <= '0;
            rp_reg         <= 8'h00;
            BUSY           <= 1'b0;
            RF_FETCH_VALID <= 1'b0;
            RF_FETCH_ADDR  <= 12'h000;
            RF_FETCH_PAIR  <= 1'b0;
        end else begin
            RF_FETCH_VALID <= 1'b0;
            case (state_reg)
                OAG_S_IDLE: begin
                    if (REQ_VALID && need_fetch) begin
                        req_reg        <= REQ;
                        rp_reg         <= REGISTER_POINTER;
                        RF_FETCH_VALID <= 1'b1;
                        RF_FETCH_ADDR  <= fetch_addr;
                        RF_FETCH_PAIR  <= fetch_pair;
                        BUSY           <= 1'b1;
                        state_reg      <= OAG_S_FETCH;
                    end
                end
                OAG_S_FETCH: state_reg <= OAG_S_USE;
                OAG_S_USE: begin
                    BUSY      <= 1'b0;
                    state_reg <= OAG_S_IDLE;
                end
                default: state_reg <= OAG_S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answer.
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            RSP <= '0;
        end else begin
            RSP <= '0;
            if (state_reg == OAG_S_IDLE && REQ_VALID && !need_fetch) begin
                case (REQ.mode)
                    OAG_M_WORK, OAG_M_REG: begin
                        RSP.rf_valid <= 1'b1;
                        RSP.rf_addr  <= first_addr;
                    end
                    OAG_M_ABS_JMP: begin
                        RSP.pc_load  <= 1'b1;
                        RSP.pc_value <= REQ.direct_program_address;
                    end
                    OAG_M_REL_JMP: begin
                        RSP.pc_load  <= 1'b1;
                        RSP.pc_value <= oag_rel(REQ.next_pc, REQ.relative_branch_offset);
                    end
                    default: RSP <= '0;
                endcase
            end else if (state_reg == OAG_S_USE) begin
                case (req_reg.mode)
                    OAG_M_IND_WORK, OAG_M_IND_REG: begin
                        RSP.rf_valid <= 1'b1;
                        RSP.rf_addr  <= {rp_reg[3:0], RF_RDATA[7:0]};
                    end
                    OAG_M_INDEX: begin
                        RSP.rf_valid <= 1'b1;
                        RSP.rf_addr  <= {rp_reg[3:0], index_sum};
                    end
                    OAG_M_IND_WPR: begin
                        if (req_reg.pair_to_program) begin
                            RSP.pm_valid <= 1'b1;
                            RSP.pm_addr  <= RF_RDATA;
                        end else begin
                            RSP.rf_valid <= 1'b1;
                            RSP.rf_addr  <= RF_RDATA[11:0];
                        end
                    end
                    OAG_M_IND_RPR: begin
                        RSP.pm_valid <= 1'b1;
                        RSP.pm_addr  <= RF_RDATA;
                    end
                    default: RSP <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    property p_reg_direct;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_IDLE && REQ_VALID && REQ.mode == OAG_M_REG
         && !(REQ.operand inside {[8'hE0:8'hEF]}))
        |=> RSP.rf_valid && RSP.rf_addr == {$past(REGISTER_POINTER[3:0]), $past(REQ.operand)};
    endproperty
    a_reg_direct: assert property (p_reg_direct) else $error("direct map wrong");

    property p_reg_escape;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_IDLE && REQ_VALID && REQ.mode == OAG_M_REG
         && REQ.operand inside {[8'hE0:8'hEF]})
        |=> RSP.rf_valid
            && RSP.rf_addr == {$past(REGISTER_POINTER[3:0]), $past(REGISTER_POINTER[7:4]),
                               $past(REQ.operand[3:0])};
    endproperty
    a_reg_escape: assert property (p_reg_escape) else $error("escape map wrong");

    property p_work;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_IDLE && REQ_VALID && REQ.mode == OAG_M_WORK)
        |=> RSP.rf_valid
            && RSP.rf_addr == {$past(REGISTER_POINTER[3:0]), $past(REGISTER_POINTER[7:4]),
                               $past(REQ.operand[3:0])};
    endproperty
    a_work: assert property (p_work) else $error("working map wrong");

    property p_ind_work;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_USE && req_reg.mode == OAG_M_IND_WORK)
        |=> RSP.rf_valid && RSP.rf_addr == {rp_reg[3:0], $past(RF_RDATA[7:0])};
    endproperty
    a_ind_work: assert property (p_ind_work) else $error("indirect work wrong");

    property p_ind_wpr;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_USE && req_reg.mode == OAG_M_IND_WPR && req_reg.pair_to_program)
        |=> RSP.pm_valid && RSP.pm_addr == $past(RF_RDATA);
    endproperty
    a_ind_wpr: assert property (p_ind_wpr) else $error("indirect pair wrong");

    property p_ind_reg;
        @(posedge CLOCK) disable iff (!RSTN)
        (REQ_VALID && state_reg == OAG_S_IDLE && REQ.mode == OAG_M_IND_REG)
        |=> RF_FETCH_VALID ##2 RSP.rf_valid;
    endproperty
    a_ind_reg: assert property (p_ind_reg) else $error("indirect reg late");

    property p_ind_rpr;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_USE && req_reg.mode == OAG_M_IND_RPR)
        |=> RSP.pm_valid && !RSP.rf_valid && RSP.pm_addr == $past(RF_RDATA);
    endproperty
    a_ind_rpr: assert property (p_ind_rpr) else $error("pair program wrong");

    property p_index;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_USE && req_reg.mode == OAG_M_INDEX)
        |=> RSP.rf_valid && RSP.rf_addr[11:8] == $past(rp_reg[3:0])
            && RSP.rf_addr[7:0] == 8'($past(req_reg.operand) + $past(RF_RDATA[7:0]));
    endproperty
    a_index: assert property (p_index) else $error("index sum wrong");

    property p_abs;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_IDLE && REQ_VALID && REQ.mode == OAG_M_ABS_JMP)
        |=> RSP.pc_load && RSP.pc_value == $past(REQ.direct_program_address);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute jump wrong");

    property p_rel;
        @(posedge CLOCK) disable iff (!RSTN)
        (state_reg == OAG_S_IDLE && REQ_VALID && REQ.mode == OAG_M_REL_JMP)
        |=> RSP.pc_value == 16'($past(REQ.next_pc)
                                + {{8{$past(REQ.relative_branch_offset[7])}},
                                   $past(REQ.relative_branch_offset)});
    endproperty
    a_rel: assert property (p_rel) else $error("relative jump wrong");

    c_index: cover property (@(posedge CLOCK) disable iff (!RSTN)
        state_reg == OAG_S_USE && req_reg.mode == OAG_M_INDEX);
    c_rel: cover property (@(posedge CLOCK) disable iff (!RSTN)
        RSP.pc_load && REQ.relative_branch_offset[7]);
    c_escape: cover property (@(posedge CLOCK) disable iff (!RSTN)
        REQ_VALID && REQ.mode == OAG_M_REG && REQ.operand inside {[8'hE0:8'hEF]});
endmodule // oag_top

// *** test_oag_top.sv ***
// Self-checking bench for the operand address generator top.
// Assumes oag_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module test_oag_top
    import oag_pkg::*;
;
    // ----------------------------------------------------------------------
    // Signals and expected rows
    // ----------------------------------------------------------------------
    typedef struct packed {
        oag_req_s    req;
        logic [7:0]  rp;
        logic [11:0] faddr;
        logic        fpair;
        oag_rsp_s    rsp;
    } oag_row_s;

    logic        CLOCK            = 1'b0;
    logic        RSTN             = 1'b0;
    logic        REQ_VALID        = 1'b0;
    oag_req_s    REQ              = '0;
    logic [7:0]  REGISTER_POINTER = 8'h00;
    logic [15:0] RF_RDATA         = 16'h0000;
    logic        BUSY;
    logic        RF_FETCH_VALID;
    logic [11:0] RF_FETCH_ADDR;
    logic        RF_FETCH_PAIR;
    oag_rsp_s    RSP;
    int          failures         = 0;
    int          checked          = 0;
    oag_row_s    rows[22];

    always #5 CLOCK = ~CLOCK;

    oag_top oag_top_i (
        .CLOCK(CLOCK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .REGISTER_POINTER(REGISTER_POINTER), .RF_RDATA(RF_RDATA), .BUSY(BUSY),
        .RF_FETCH_VALID(RF_FETCH_VALID), .RF_FETCH_ADDR(RF_FETCH_ADDR),
        .RF_FETCH_PAIR(RF_FETCH_PAIR), .RSP(RSP)
    );

    // ----------------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------------
    // A fetch row reuses the 16-bit argument as the register file answer.
    function automatic oag_row_s row(oag_mode_e m, logic [7:0] op, logic [15:0] aux,
            logic [7:0] ofs, logic [7:0] rp, logic [11:0] fa, logic fp,
            logic [1:0] k, logic [15:0] v);
        row = '0;
        row.req = '{m, op, aux, ofs, aux, (k == 2'h1)};
        row.rp = rp;
        row.faddr = fa;
        row.fpair = fp;
        row.rsp.rf_valid = (k == 2'h0);
        row.rsp.rf_addr  = (k == 2'h0) ? v[11:0] : 12'h000;
        row.rsp.pm_valid = (k == 2'h1);
        row.rsp.pm_addr  = (k == 2'h1) ? v : 16'h0000;
        row.rsp.pc_load  = (k == 2'h2);
        row.rsp.pc_value = (k == 2'h2) ? v : 16'h0000;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // With poke set, a jump request is offered while busy and must be ignored.
    task automatic run(input oag_row_s r, input logic poke);
        int w;
        @(posedge CLOCK);
        REQ <= r.req;
        REGISTER_POINTER <= r.rp;
        REQ_VALID <= 1'b1;
        @(posedge CLOCK);
        REQ <= rows[8].req;
        REQ_VALID <= poke;
        #1;
        if (r.faddr == 12'h000) begin
            check(64'(RSP), 64'(r.rsp));
        end else begin
            check(64'({BUSY, RF_FETCH_VALID, RF_FETCH_PAIR, RF_FETCH_ADDR}),
                  64'({2'b11, r.fpair, r.faddr}));
            @(posedge CLOCK);
            REQ_VALID <= 1'b0;
            RF_RDATA <= r.req.next_pc;
            #1;
            check(64'(RSP), 64'h0);
            w = 0;
            do begin
                @(posedge CLOCK);
                #1;
                w++;
            end while (RSP.rf_valid !== 1'b1 && RSP.pm_valid !== 1'b1 && w < 6);
            check(64'({BUSY, RSP}), 64'({1'b0, r.rsp}));
            @(posedge CLOCK);
            RF_RDATA <= ~r.req.next_pc;
        end
    endtask

    // ----------------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------------
    initial begin
        rows = '{
            row(OAG_M_REG, 8'hDF, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0ADF),
            row(OAG_M_REG, 8'hF0, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0AF0),
            row(OAG_M_REG, 8'hFF, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0AFF),
            row(OAG_M_REG, 8'hE0, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0A50),
            row(OAG_M_REG, 8'hEF, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0A5F),
            row(OAG_M_WORK, 8'h03, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h0, 16'h0A53),
            row(OAG_M_WORK, 8'h0F, 16'h0000, 8'h00, 8'hC3, 12'h000, 1'b0, 2'h0, 16'h03CF),
            row(OAG_M_ABS_JMP, 8'h00, 16'h0000, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h2, 16'h0000),
            row(OAG_M_ABS_JMP, 8'h00, 16'hFFFF, 8'h00, 8'h5A, 12'h000, 1'b0, 2'h2, 16'hFFFF),
            row(OAG_M_REL_JMP, 8'h00, 16'h1000, 8'h7F, 8'h5A, 12'h000, 1'b0, 2'h2, 16'h107F),
            row(OAG_M_REL_JMP, 8'h00, 16'h1000, 8'h80, 8'h5A, 12'h000, 1'b0, 2'h2, 16'h0F80),
            row(OAG_M_REL_JMP, 8'h00, 16'hFFF0, 8'h20, 8'h5A, 12'h000, 1'b0, 2'h2, 16'h0010),
            row(OAG_M_IND_WORK, 8'h07, 16'hA5C4, 8'h00, 8'h5A, 12'hA57, 1'b0, 2'h0, 16'h0AC4),
            row(OAG_M_IND_WPR, 8'h04, 16'hF123, 8'h00, 8'h5A, 12'hA54, 1'b1, 2'h0, 16'h0123),
            row(OAG_M_IND_WPR, 8'h0E, 16'hBEEF, 8'h00, 8'h5A, 12'hA5E, 1'b1, 2'h1, 16'hBEEF),
            row(OAG_M_IND_REG, 8'h30, 16'h1177, 8'h00, 8'h5A, 12'hA30, 1'b0, 2'h0, 16'h0A77),
            row(OAG_M_IND_REG, 8'hE2, 16'h00FE, 8'h00, 8'h5A, 12'hA52, 1'b0, 2'h0, 16'h0AFE),
            row(OAG_M_IND_RPR, 8'hE6, 16'hFFFF, 8'h00, 8'h5A, 12'hA56, 1'b1, 2'h1, 16'hFFFF),
            row(OAG_M_IND_RPR, 8'h40, 16'h1234, 8'h00, 8'h5A, 12'hA40, 1'b1, 2'h1, 16'h1234),
            row(OAG_M_INDEX, 8'h10, 16'h00FE, 8'h03, 8'h5A, 12'hA53, 1'b0, 2'h0, 16'h0A0E),
            row(OAG_M_INDEX, 8'hF0, 16'h0020, 8'h0C, 8'h5A, 12'hA5C, 1'b0, 2'h0, 16'h0A10),
            row(OAG_M_INDEX, 8'h80, 16'h007F, 8'h01, 8'h5A, 12'hA51, 1'b0, 2'h0, 16'h0AFF)};
        repeat (15) @(posedge CLOCK);
        #1;
        check(64'({BUSY, RF_FETCH_VALID, RSP}), 64'h0);
        @(posedge CLOCK);
        RSTN <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
        end
        // Back-to-back direct requests, no idle cycle between them.
        @(posedge CLOCK);
        REQ <= rows[0].req;
        REGISTER_POINTER <= rows[0].rp;
        REQ_VALID <= 1'b1;
        @(posedge CLOCK);
        REQ <= rows[10].req;
        #1;
        check(64'(RSP), 64'(rows[0].rsp));
        @(posedge CLOCK);
        REQ_VALID <= 1'b0;
        #1;
        check(64'(RSP), 64'(rows[10].rsp));
        run(rows[16], 1'b1);
        // A reset in mid-fetch must abandon the fetch before the answer.
        @(posedge CLOCK);
        REQ <= rows[17].req;
        REQ_VALID <= 1'b1;
        @(posedge CLOCK);
        REQ_VALID <= 1'b0;
        RSTN <= 1'b0;
        @(posedge CLOCK);
        RSTN <= 1'b1;
        #1;
        check(64'({BUSY, RF_FETCH_VALID, RSP}), 64'h0);
        run(rows[19], 1'b0);
        test_done();
    end

    initial begin
        #100000;
        failures++;
        test_done();
    end
endmodule // test_oag_top
